// ---- common/svc_pkg.sv ----
// Constants shared by the service request decoder
package svc_pkg;
   // Service selector codes handled by this block
   localparam logic [7:0] FN_SWEEP = 8'h01;
   localparam logic [7:0] FN_WINRD = 8'h02;
   localparam logic [7:0] FN_WINPRG = 8'h03;
   localparam logic [7:0] FN_WINSYS = 8'h04;
   localparam logic [7:0] FN_CSUM = 8'h06;
   localparam logic [7:0] FN_TOD = 8'h07;
   // Operation codes in the first block word
   localparam logic [15:0] OP_0 = 16'h0000;
   localparam logic [15:0] OP_1 = 16'h0001;
   localparam logic [15:0] OP_2 = 16'h0002;
   localparam logic [15:0] OP_3 = 16'h0003;
   // Window modes and fixed window time
   localparam logic [7:0] MODE_LIMITED = 8'h00;
   localparam logic [7:0] MODE_RTC = 8'h02;
   localparam logic [7:0] WIN_TIME_MS = 8'h06;
   // Value limits
   localparam logic [15:0] SWEEP_MAX_MS = 16'h01f4;
   localparam logic [15:0] CSUM_MAX = 16'h0020;
   // Clock formats and block lengths
   localparam logic [15:0] FMT_BCD2 = 16'h0001;
   localparam logic [15:0] FMT_ASC2 = 16'h0003;
   localparam logic [15:0] FMT_BCD4 = 16'h0081;
   localparam logic [15:0] FMT_ASC4 = 16'h0083;
   localparam logic [3:0] LEN_BCD = 4'h6;
   localparam logic [3:0] LEN_ASC2 = 4'hc;
   localparam logic [3:0] LEN_ASC4 = 4'hd;
   localparam logic [3:0] LEN_HDR = 4'h2;
   localparam logic [3:0] LEN_WIN = 4'h3;
   localparam logic [3:0] LEN_MODE = 4'h1;
   // Clock byte fields: year high, year low, month, day, hour, minute, second, weekday
   localparam logic [3:0] F_NULL = 4'h8;
   localparam logic [3:0] BCD2_MAP [0:7] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
   localparam logic [3:0] BCD4_MAP [0:7] = '{4'h1, 4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
   // ASCII stream: nibble index below 10h, 10h space, 11h colon
   localparam logic [4:0] ASC_MAP [0:21] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h04,
      5'h05, 5'h10, 5'h06, 5'h07, 5'h10, 5'h08, 5'h09, 5'h11, 5'h0a, 5'h0b, 5'h11,
      5'h0c, 5'h0d, 5'h10, 5'h0e, 5'h0f};
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_COLON = 8'h3a;
   localparam logic [7:0] CH_ZERO = 8'h30;
   // Clock value after reset: 2000-01-01 00:00:00, Saturday
   localparam logic [63:0] TOD_RST = 64'h0700_0000_0101_0020;
   // Register offsets and reset values
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_SWEEP = 4'h1;
   localparam logic [3:0] REG_CSUM = 4'h2;
   localparam logic [3:0] REG_CTRL = 4'h3;
   localparam logic CTRL_RST = 1'b1;
   localparam logic [15:0] MEM_LAST_DEF = 16'hffff;
   // Window timing
   localparam int CLK_HZ = 125000000;
   localparam int WIN_LIM_MS = 6;
   localparam int WIN_RTC_MS = 400;
   localparam int WIN_LIM_CYC_DEF = WIN_LIM_MS * (CLK_HZ / 1000);
   localparam int WIN_RTC_CYC_DEF = WIN_RTC_MS * (CLK_HZ / 1000);
endpackage : svc_pkg

// ---- hw/svc_request_decoder.sv ----
// Service request decoder: parameter block interpreter for six services
// What this block does
// - Sweep op 0 turns constant sweep off; second word ignored.
// - Sweep op 1 turns sweep on; nonzero second word replaces timer value.
// - Sweep on with zero word and zero held timer fails.
// - Sweep op 2 loads the timer value, mode unchanged.
// - Sweep op 3 writes mode and timer back into the block.
// - Sweep fails on any op code other than 0 to 3.
// - Sweep fails when timer value exceeds 500 ms.
// - Limited window ends on no tasks or after 6 ms.
// - Run-to-completion window runs until tasks finish, at most 400 ms.
// - A window with zero time is disabled.
// - Window read fills three words: programmer, system, zero.
// - Window mode change applies next sweep; time stays 6 ms.
// - Window mode change succeeds only for mode 0 or 2.
// - Checksum op 0 returns the word count in the second word.
// - Checksum op 1 sets word count, range 0 to 32.
// - Checksum fails on op codes other than 0 and 1.
// - Clock word 0 reads or sets; word 1 picks one of four formats.
// - Clock block is 6 words BCD, 12 or 13 words ASCII.
// - Hours are 24-hour; weekday runs 1 Sunday to 7 Saturday.
// - Clock data words share layout; ignored as input on read.
// - Clock fails on bad op, bad format or malformed data.
// - Service runs on enable; ok only on error-free completion.
`timescale 1ns/100ps
module svc_request_decoder import svc_pkg::*; #(
   parameter int WIN_LIM_CYC = WIN_LIM_CYC_DEF,
   parameter int WIN_RTC_CYC = WIN_RTC_CYC_DEF,
   parameter logic [15:0] MEM_LAST = MEM_LAST_DEF
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic svc_req,
   input wire logic [7:0] function_selector,
   input wire logic [15:0] argument_block_base,
   output logic svc_done,
   output logic svc_ok,
   output logic svc_busy,
   output logic [15:0] mem_addr,
   output logic [15:0] mem_wdata,
   output logic mem_re,
   output logic mem_we,
   input wire logic [15:0] mem_rdata,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [15:0] reg_rdata,
   input wire logic sweep_start,
   input wire logic win_start,
   input wire logic win_sel,
   input wire logic win_tasks_pending,
   output logic const_sweep_en,
   output logic [15:0] const_sweep_ms,
   output logic win_active
);
   typedef enum logic [2:0] {S_IDLE, S_RD, S_CAP, S_EXEC, S_WR, S_DONE} svc_st_t;
   typedef struct packed {
      svc_st_t st;
      logic [3:0] idx;
      logic [7:0] func;
      logic [15:0] base;
      logic [12:0][15:0] blk;
      logic [3:0] whi;
      logic res;
      logic ok;
      logic done;
      logic busy;
      logic mem_re;
      logic mem_we;
      logic [15:0] mem_addr;
      logic [15:0] mem_wdata;
      logic [15:0] reg_rdata;
      logic ctrl_en;
      logic sweep_en;
      logic [15:0] sweep_time;
      logic [15:0] csum;
      logic [7:0] pmode_p;
      logic [7:0] pmode_s;
      logic [7:0] mode_p;
      logic [7:0] mode_s;
      logic [7:0][7:0] tod;
      logic win_act;
      logic [25:0] win_cnt;
      logic [25:0] win_lim;
   } svc_state_t;

   localparam svc_state_t SVC_RST = '{st: S_IDLE, ctrl_en: CTRL_RST, tod: TOD_RST,
      default: '0};

   svc_state_t s_r;
   svc_state_t s_nxt;

   // Clock helpers, derived from the captured block
   logic fmt_ok;
   logic fmt_asc;
   logic fmt_y4;
   logic [3:0] tod_len;
   logic tod_data_ok;
   logic [7:0][7:0] tod_cand;
   logic [12:0][15:0] tod_out;
   logic [3:0] rd_len;

   // Byte i of the clock data stream, starting at word 2, low byte first
   function automatic logic [7:0] dbyte(input logic [12:0][15:0] b, input int i);
      logic [15:0] w;
      w = b[2 + i / 2];
      return (i % 2 == 1) ? w[15:8] : w[7:0];
   endfunction : dbyte

   // Two-digit BCD byte within lo..hi
   function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo,
                                   input logic [7:0] hi);
      return (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
   endfunction : bcd_in

   // Clock format decode, data parse for set, data build for read
   always_comb begin
      int off;
      int m;
      logic [7:0] ch;
      logic [3:0] f;
      off = 0;
      m = 0;
      ch = '0;
      f = '0;
      fmt_asc = s_r.blk[1][1];
      fmt_y4 = s_r.blk[1][7];
      fmt_ok = (s_r.blk[1] == FMT_BCD2) || (s_r.blk[1] == FMT_ASC2) ||
               (s_r.blk[1] == FMT_BCD4) || (s_r.blk[1] == FMT_ASC4);
      tod_len = fmt_asc ? (fmt_y4 ? LEN_ASC4 : LEN_ASC2) : LEN_BCD;
      tod_cand = s_r.tod;
      tod_data_ok = 1'b1;
      tod_out = s_r.blk;
      if (!fmt_asc) begin
         for (int i = 0; i < 8; i++) begin
            f = fmt_y4 ? BCD4_MAP[i] : BCD2_MAP[i];
            if (f != F_NULL) begin
               tod_cand[f[2:0]] = dbyte(s_r.blk, i);
            end
            // Unused null byte reads back as zero
            if (i % 2 == 1) begin
               tod_out[2 + i / 2][15:8] = (f == F_NULL) ? 8'h00 : s_r.tod[f[2:0]];
            end else begin
               tod_out[2 + i / 2][7:0] = (f == F_NULL) ? 8'h00 : s_r.tod[f[2:0]];
            end
         end
      end else begin
         off = fmt_y4 ? 0 : 2;
         for (int j = 0; j < 22; j++) begin
            if (j >= off) begin
               ch = dbyte(s_r.blk, j - off);
               m = int'(ASC_MAP[j]);
               if (m < 16) begin
                  if (ch < CH_ZERO || ch > 8'h39) begin
                     tod_data_ok = 1'b0;
                  end
                  if (m % 2 == 0) begin
                     tod_cand[m / 2][7:4] = ch[3:0];
                  end else begin
                     tod_cand[m / 2][3:0] = ch[3:0];
                  end
                  ch = CH_ZERO | {4'h0, (m % 2 == 0) ? s_r.tod[m / 2][7:4]
                                                    : s_r.tod[m / 2][3:0]};
               end else begin
                  if (ch != ((m == 16) ? CH_SPACE : CH_COLON)) begin
                     tod_data_ok = 1'b0;
                  end
                  ch = (m == 16) ? CH_SPACE : CH_COLON;
               end
               if ((j - off) % 2 == 1) begin
                  tod_out[2 + (j - off) / 2][15:8] = ch;
               end else begin
                  tod_out[2 + (j - off) / 2][7:0] = ch;
               end
            end
         end
      end
      // Field ranges: 24-hour clock, weekday 1 Sunday to 7 Saturday
      if (!(bcd_in(tod_cand[0], 8'h00, 8'h99) && bcd_in(tod_cand[1], 8'h00, 8'h99) &&
            bcd_in(tod_cand[2], 8'h01, 8'h12) && bcd_in(tod_cand[3], 8'h01, 8'h31) &&
            bcd_in(tod_cand[4], 8'h00, 8'h23) && bcd_in(tod_cand[5], 8'h00, 8'h59) &&
            bcd_in(tod_cand[6], 8'h00, 8'h59) && bcd_in(tod_cand[7], 8'h01, 8'h07))) begin
         tod_data_ok = 1'b0;
      end
      // Words to fetch; clock data is fetched only for a set
      case (s_r.func)
         FN_SWEEP, FN_CSUM: rd_len = LEN_HDR;
         FN_WINPRG, FN_WINSYS: rd_len = LEN_MODE;
         FN_TOD: rd_len = (s_r.idx >= LEN_HDR && s_r.blk[0] == OP_1 && fmt_ok) ?
                          tod_len : LEN_HDR;
         default: rd_len = 4'h0;
      endcase
   end

   // Next state of the whole block
   always_comb begin
      logic wr;
      logic [3:0] wlo;
      logic [15:0] w0;
      logic [15:0] w1;
      logic [7:0] md;
      wr = 1'b0;
      wlo = '0;
      w0 = s_r.blk[0];
      w1 = s_r.blk[1];
      md = s_r.blk[0][15:8];
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      s_nxt.mem_re = 1'b0;
      s_nxt.mem_we = 1'b0;
      case (s_r.st)
         S_IDLE: begin
            if (svc_req) begin
               s_nxt.func = function_selector;
               s_nxt.base = argument_block_base;
               s_nxt.busy = 1'b1;
               s_nxt.idx = '0;
               s_nxt.res = 1'b0;
               s_nxt.st = S_RD;
               // Unknown selector or disabled block completes as a failure
               if (!s_r.ctrl_en || !(function_selector inside {FN_SWEEP, FN_WINRD,
                   FN_WINPRG, FN_WINSYS, FN_CSUM, FN_TOD})) begin
                  s_nxt.st = S_DONE;
               end
            end
         end
         S_RD: begin
            if (s_r.idx >= rd_len) begin
               s_nxt.st = S_EXEC;
            end else if ({1'b0, s_r.base} + {13'h0, s_r.idx} > {1'b0, MEM_LAST}) begin
               s_nxt.st = S_DONE;
            end else begin
               s_nxt.mem_re = 1'b1;
               s_nxt.mem_addr = s_r.base + {12'h0, s_r.idx};
               s_nxt.st = S_CAP;
            end
         end
         S_CAP: begin
            s_nxt.blk[s_r.idx] = mem_rdata;
            s_nxt.idx = s_r.idx + 4'h1;
            s_nxt.st = S_RD;
         end
         S_EXEC: begin
            s_nxt.st = S_DONE;
            case (s_r.func)
               FN_SWEEP: begin
                  case (w0)
                     OP_0: begin
                        s_nxt.sweep_en = 1'b0;
                        s_nxt.res = 1'b1;
                     end
                     OP_1: begin
                        if (w1 > SWEEP_MAX_MS) begin
                           s_nxt.res = 1'b0;
                        end else if (w1 != 16'h0000) begin
                           s_nxt.sweep_en = 1'b1;
                           s_nxt.sweep_time = w1;
                           s_nxt.res = 1'b1;
                        end else if (s_r.sweep_time == 16'h0000) begin
                           s_nxt.res = 1'b0;
                        end else begin
                           s_nxt.sweep_en = 1'b1;
                           s_nxt.res = 1'b1;
                        end
                     end
                     OP_2: begin
                        if (w1 > SWEEP_MAX_MS) begin
                           s_nxt.res = 1'b0;
                        end else begin
                           s_nxt.sweep_time = w1;
                           s_nxt.res = 1'b1;
                        end
                     end
                     OP_3: begin
                        s_nxt.blk[0] = {15'h0000, s_r.sweep_en};
                        s_nxt.blk[1] = s_r.sweep_time;
                        s_nxt.whi = 4'h1;
                        wr = 1'b1;
                        s_nxt.res = 1'b1;
                     end
                     default: s_nxt.res = 1'b0;
                  endcase
               end
               FN_WINRD: begin
                  s_nxt.blk[0] = {s_r.mode_p, WIN_TIME_MS};
                  s_nxt.blk[1] = {s_r.mode_s, WIN_TIME_MS};
                  s_nxt.blk[2] = 16'h0000;
                  s_nxt.whi = LEN_WIN - 4'h1;
                  wr = 1'b1;
                  s_nxt.res = 1'b1;
               end
               FN_WINPRG, FN_WINSYS: begin
                  // Low byte is the fixed time the caller supplies; not stored
                  if (md == MODE_LIMITED || md == MODE_RTC) begin
                     if (s_r.func == FN_WINPRG) begin
                        s_nxt.pmode_p = md;
                     end else begin
                        s_nxt.pmode_s = md;
                     end
                     s_nxt.res = 1'b1;
                  end
               end
               FN_CSUM: begin
                  case (w0)
                     OP_0: begin
                        s_nxt.blk[1] = s_r.csum;
                        wlo = 4'h1;
                        s_nxt.whi = 4'h1;
                        wr = 1'b1;
                        s_nxt.res = 1'b1;
                     end
                     OP_1: begin
                        if (w1 <= CSUM_MAX) begin
                           s_nxt.csum = w1;
                           s_nxt.res = 1'b1;
                        end
                     end
                     default: s_nxt.res = 1'b0;
                  endcase
               end
               default: begin
                  // Time-of-day clock read or set
                  if (w0 > OP_1 || !fmt_ok) begin
                     s_nxt.res = 1'b0;
                  end else if (w0 == OP_1) begin
                     if (tod_data_ok) begin
                        s_nxt.tod = tod_cand;
                        s_nxt.res = 1'b1;
                     end
                  end else begin
                     s_nxt.blk = tod_out;
                     wlo = LEN_HDR;
                     s_nxt.whi = tod_len - 4'h1;
                     wr = 1'b1;
                     s_nxt.res = 1'b1;
                  end
               end
            endcase
            // Write-back only if every word of it lies in memory
            if (wr) begin
               if ({1'b0, s_r.base} + {13'h0, s_nxt.whi} > {1'b0, MEM_LAST}) begin
                  s_nxt.res = 1'b0;
               end else begin
                  s_nxt.idx = wlo;
                  s_nxt.st = S_WR;
               end
            end
         end
         S_WR: begin
            s_nxt.mem_we = 1'b1;
            s_nxt.mem_addr = s_r.base + {12'h0, s_r.idx};
            s_nxt.mem_wdata = s_r.blk[s_r.idx];
            s_nxt.idx = s_r.idx + 4'h1;
            if (s_r.idx == s_r.whi) begin
               s_nxt.st = S_DONE;
            end
         end
         default: begin
            // Result becomes visible together with the done pulse
            s_nxt.done = 1'b1;
            s_nxt.ok = s_r.res;
            s_nxt.busy = 1'b0;
            s_nxt.st = S_IDLE;
         end
      endcase

      // Pending window modes take effect at the next sweep
      if (sweep_start) begin
         s_nxt.mode_p = s_nxt.pmode_p;
         s_nxt.mode_s = s_nxt.pmode_s;
      end

      // Communications window timing
      if (s_r.win_act) begin
         if (!win_tasks_pending || s_r.win_cnt >= s_r.win_lim) begin
            s_nxt.win_act = 1'b0;
         end else begin
            s_nxt.win_cnt = s_r.win_cnt + 26'h1;
         end
      end else if (win_start && WIN_TIME_MS != 8'h00) begin
         s_nxt.win_act = 1'b1;
         s_nxt.win_cnt = 26'h1;
         if ((win_sel ? s_r.mode_s : s_r.mode_p) == MODE_RTC) begin
            s_nxt.win_lim = 26'(WIN_RTC_CYC);
         end else begin
            s_nxt.win_lim = 26'(WIN_LIM_CYC);
         end
      end

      // Register port
      if (reg_we && reg_addr == REG_CTRL) begin
         s_nxt.ctrl_en = reg_wdata[0];
      end
      s_nxt.reg_rdata = 16'h0000;
      if (reg_re) begin
         if (reg_addr == REG_STATUS) begin
            s_nxt.reg_rdata = {s_r.mode_s[1:0], s_r.mode_p[1:0], 9'h000,
                               s_r.win_act, s_r.sweep_en, s_r.busy};
         end else if (reg_addr == REG_SWEEP) begin
            s_nxt.reg_rdata = s_r.sweep_time;
         end else if (reg_addr == REG_CSUM) begin
            s_nxt.reg_rdata = s_r.csum;
         end else if (reg_addr == REG_CTRL) begin
            s_nxt.reg_rdata = {15'h0000, s_r.ctrl_en};
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= SVC_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign svc_done = s_r.done;
   assign svc_ok = s_r.ok;
   assign svc_busy = s_r.busy;
   assign mem_addr = s_r.mem_addr;
   assign mem_wdata = s_r.mem_wdata;
   assign mem_re = s_r.mem_re;
   assign mem_we = s_r.mem_we;
   assign reg_rdata = s_r.reg_rdata;
   assign const_sweep_en = s_r.sweep_en;
   assign const_sweep_ms = s_r.sweep_time;
   assign win_active = s_r.win_act;

   // Checks on completed requests and window timing
   sweep_off_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && s_r.ok && s_r.func == FN_SWEEP && s_r.blk[0] == OP_0 |-> !s_r.sweep_en)
      else $error("sweep still on after disable");
   sweep_on_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && s_r.ok && s_r.func == FN_SWEEP && s_r.blk[0] == OP_1
      |-> s_r.sweep_en && s_r.sweep_time != 16'h0000)
      else $error("sweep enabled without timer");
   sweep_op_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && s_r.func == FN_SWEEP && s_r.blk[0] > OP_3 |-> !s_r.ok)
      else $error("bad sweep op passed");
   sweep_max_a: assert property (@(posedge clk) disable iff (!rst_b)
      $changed(s_r.sweep_time) |-> s_r.sweep_time <= SWEEP_MAX_MS)
      else $error("sweep time above limit");
   csum_range_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && s_r.func == FN_CSUM && s_r.blk[0] == OP_1
      |-> s_r.ok == (s_r.blk[1] <= CSUM_MAX))
      else $error("checksum count range wrong");
   win_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && (s_r.func == FN_WINPRG || s_r.func == FN_WINSYS)
      |-> s_r.ok == (s_r.blk[0][15:8] == MODE_LIMITED || s_r.blk[0][15:8] == MODE_RTC))
      else $error("window mode result wrong");
   mode_apply_a: assert property (@(posedge clk) disable iff (!rst_b)
      sweep_start |=> s_r.mode_p == s_r.pmode_p && s_r.mode_s == s_r.pmode_s)
      else $error("window mode not applied");
   win_end_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.win_act && !win_tasks_pending |=> !s_r.win_act)
      else $error("window outlived its tasks");
   tod_op_a: assert property (@(posedge clk) disable iff (!rst_b)
      s_r.done && s_r.func == FN_TOD && s_r.blk[0] > OP_1 |-> !s_r.ok)
      else $error("bad clock op passed");
   req_done_a: assert property (@(posedge clk) disable iff (!rst_b)
      svc_req && !s_r.busy |-> ##[1:60] s_r.done)
      else $error("request not completed");
   bad_fn_a: assert property (@(posedge clk) disable iff (!rst_b)
      svc_req && !s_r.busy && function_selector == 8'h05 |=> ##1 s_r.done && !s_r.ok)
      else $error("unknown selector passed");
endmodule : svc_request_decoder

// ---- dv/svc_request_decoder_tb.sv ----
// Self-checking bench for the service request decoder
`timescale 1ns/100ps
module svc_request_decoder_tb import svc_pkg::*; ;
   logic clk = 0, rst_b = 0, svc_req = 0, reg_we = 0, reg_re = 0, rv_d = 0;
   logic sweep_start = 0, win_start = 0, win_sel = 0, win_tasks_pending = 0;
   logic [7:0] fsel = 0;
   logic [15:0] base = 0, mem_rdata, reg_wdata = 0, tv;
   logic [3:0] reg_addr = 0;
   logic svc_done, svc_ok, svc_busy, mem_re, mem_we, const_sweep_en, win_active;
   logic [15:0] mem_addr, mem_wdata, reg_rdata, const_sweep_ms;
   logic [15:0] mem [0:63];
   logic okq [$];
   logic [15:0] rq [$];
   int errors = 0, checks = 0, seed = 32'h0a677067, n;
   svc_request_decoder #(.WIN_LIM_CYC(20), .WIN_RTC_CYC(60), .MEM_LAST(16'h003f)) uut (
      .clk(clk), .rst_b(rst_b), .svc_req(svc_req), .function_selector(fsel),
      .argument_block_base(base), .svc_done(svc_done), .svc_ok(svc_ok),
      .svc_busy(svc_busy), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_re(mem_re),
      .mem_we(mem_we), .mem_rdata(mem_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sweep_start(sweep_start),
      .win_start(win_start), .win_sel(win_sel), .win_tasks_pending(win_tasks_pending),
      .const_sweep_en(const_sweep_en), .const_sweep_ms(const_sweep_ms),
      .win_active(win_active));
   // Clock at 8 ns period
   initial forever #4 clk = ~clk;
   // Word memory: read data follows the address, the decoder captures in the strobe cycle
   assign mem_rdata = mem[mem_addr[5:0]];
   always @(posedge clk) begin
      rv_d <= reg_re;
      if (mem_we === 1'b1) mem[mem_addr[5:0]] <= mem_wdata;
   end
   // Result watcher takes the oldest note on each completion
   always @(negedge clk) begin
      if (svc_done === 1'b1) chk("svc_ok", {15'h0, svc_ok}, {15'h0, okq.pop_front()});
      if (rv_d) chk("reg_rdata", reg_rdata, rq.pop_front());
   end
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wrap_up;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up
   // One request, waiting for completion under a bound
   task automatic svc(input logic [7:0] f, input logic [15:0] b, input logic ok);
      @(posedge clk);
      svc_req <= 1;
      fsel <= f;
      base <= b;
      @(posedge clk);
      svc_req <= 0;
      okq.push_back(ok);
      n = 0;
      while (svc_done !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (svc_done !== 1'b1) begin
         errors++;
         wrap_up();
      end
   endtask : svc
   task automatic sw(input logic [15:0] op, input logic [15:0] v, input logic ok);
      mem[8] = op;
      mem[9] = v;
      svc(FN_SWEEP, 16'h8, ok);
   endtask : sw
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_re <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 0;
      rq.push_back(e);
   endtask : rd
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_we <= 1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 0;
   endtask : wr
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1;
      tv = 16'({$random(seed)} % 500) + 16'h1;
      sw(OP_1, tv, 1);
      sw(OP_1, 16'h0, 1);
      chk("sweep_ms", const_sweep_ms, tv);
      rd(REG_SWEEP, tv);
      rd(4'h4, 16'h0);
      sw(OP_3, 16'hbeef, 1);
      chk("rd_en", mem[8], 16'h1);
      chk("rd_ms", mem[9], tv);
      sw(OP_2, SWEEP_MAX_MS, 1);
      sw(OP_2, SWEEP_MAX_MS + 16'h1, 0);
      sw(16'h4, 16'h1, 0);
      chk("sweep_en", {15'h0, const_sweep_en}, 16'h1);
      chk("sweep_ms", const_sweep_ms, SWEEP_MAX_MS);
      sw(OP_0, 16'h1234, 1);
      sw(OP_2, 16'h0, 1);
      sw(OP_1, 16'h0, 0);
      chk("sweep_en", {15'h0, const_sweep_en}, 16'h0);
      mem[63] = OP_3;
      svc(FN_SWEEP, 16'h3f, 0);
      chk("oor_word", mem[63], OP_3);
      $display("sweep tests done");
      mem[20] = 16'h0506;
      svc(FN_WINPRG, 16'd20, 0);
      mem[20] = {MODE_RTC, WIN_TIME_MS};
      svc(FN_WINPRG, 16'd20, 1);
      mem[18] = 16'hffff;
      svc(FN_WINRD, 16'd16, 1);
      chk("win_prg", mem[16], {MODE_LIMITED, WIN_TIME_MS});
      chk("win_rsv", mem[18], 16'h0);
      @(posedge clk) sweep_start <= 1;
      @(posedge clk) sweep_start <= 0;
      svc(FN_WINRD, 16'd16, 1);
      chk("win_prg", mem[16], {MODE_RTC, WIN_TIME_MS});
      chk("win_sys", mem[17], {MODE_LIMITED, WIN_TIME_MS});
      @(posedge clk);
      win_sel <= 1;
      win_tasks_pending <= 1;
      win_start <= 1;
      @(posedge clk) win_start <= 0;
      repeat (10) @(negedge clk);
      chk("win_open", {15'h0, win_active}, 16'h1);
      repeat (15) @(negedge clk);
      chk("win_limit", {15'h0, win_active}, 16'h0);
      // Programmer window in run-to-completion outlives the limited budget, ends with its tasks
      @(posedge clk);
      win_sel <= 0;
      win_start <= 1;
      @(posedge clk) win_start <= 0;
      repeat (30) @(negedge clk);
      chk("win_rtc", {15'h0, win_active}, 16'h1);
      @(posedge clk) win_tasks_pending <= 0;
      repeat (2) @(negedge clk);
      chk("win_tasks", {15'h0, win_active}, 16'h0);
      $display("window tests done");
      mem[24] = OP_1;
      mem[25] = CSUM_MAX;
      svc(FN_CSUM, 16'd24, 1);
      mem[24] = OP_0;
      mem[25] = 16'h0;
      svc(FN_CSUM, 16'd24, 1);
      chk("csum_cnt", mem[25], CSUM_MAX);
      rd(REG_CSUM, CSUM_MAX);
      mem[24] = OP_2;
      svc(FN_CSUM, 16'd24, 0);
      mem[24] = OP_1;
      mem[25] = CSUM_MAX + 16'h1;
      svc(FN_CSUM, 16'd24, 0);
      mem[32] = OP_0;
      mem[33] = FMT_BCD4;
      mem[38] = 16'h5a5a;
      svc(FN_TOD, 16'd32, 1);
      chk("tod_year", mem[34], 16'h2000);
      chk("tod_dow", mem[37], 16'h0700);
      chk("tod_len", mem[38], 16'h5a5a);
      mem[33] = 16'h0002;
      svc(FN_TOD, 16'd32, 0);
      mem[32] = OP_2;
      mem[33] = FMT_BCD2;
      svc(FN_TOD, 16'd32, 0);
      // Set in four-digit BCD: hour 24 refused, then a valid date, read back as ASCII
      mem[32] = OP_1;
      mem[33] = FMT_BCD4;
      mem[34] = 16'h1998;
      mem[35] = 16'h0307;
      mem[36] = 16'h4524;
      mem[37] = 16'h0130;
      svc(FN_TOD, 16'd32, 0);
      mem[36] = 16'h4514;
      svc(FN_TOD, 16'd32, 1);
      mem[32] = OP_0;
      mem[33] = FMT_ASC4;
      svc(FN_TOD, 16'd32, 1);
      chk("tod_asc_yr", mem[34], 16'h3931);
      chk("tod_asc_dow", mem[44], 16'h3130);
      svc(8'h05, 16'd32, 0);
      wr(REG_CTRL, 16'h0);
      svc(FN_WINRD, 16'd16, 0);
      wr(REG_CTRL, 16'h1);
      $display("checksum clock register tests done");
      repeat (3) @(posedge clk);
      wrap_up();
   end
endmodule : svc_request_decoder_tb
